// [hw/rx_status_defs.svh]
// Offsets, bit positions and reset values of the receiver status block
`ifndef RX_STATUS_DEFS_SVH
`define RX_STATUS_DEFS_SVH

`define OFF_RSC 4'h0
`define OFF_RECEIVE_BUFFER 4'h4
`define OFF_IRQ_STS 4'h8
`define OFF_IRQ_MASK 4'hc

`define B_MODEM_CHG 15
`define B_RING 14
`define B_CTS 13
`define B_CARRIER 12
`define B_BUSY 11
`define B_SEC_RX 10
`define B_RX_DONE 7
`define B_RX_IE 6
`define B_MODEM_IE 5
`define B_SEC_TX 3
`define B_RTS 2
`define B_DTR 1
`define B_TAPE 0

`define IRQ_RX 0
`define IRQ_MODEM 1

`define RST_IRQ2 2'h0
`define RST_BYTE 8'h00

`endif

// [hw/rx_status_pkg.sv]
// Types shared by the receiver status block
package rx_status_pkg;

    typedef struct packed {
        logic carrier;
        logic cts;
        logic ring;
        logic sec_rx;
    } modem_lines_t;

    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_SLVERR = 2'b10
    } resp_t;

    typedef enum logic [2:0] {
        SEL_RSC = 3'b000,
        SEL_RECEIVE_BUFFER = 3'b001,
        SEL_IRQ_STS = 3'b010,
        SEL_IRQ_MASK = 3'b011,
        SEL_NONE = 3'b100
    } reg_sel_t;

endpackage : rx_status_pkg

// [hw/modem_watch.sv]
// Registers the modem lines and flags any change of interest
`timescale 1ns/1ps
`include "rx_status_defs.svh"

module modem_watch (
    input wire logic aclk,
    input wire logic aresetn,
    input wire rx_status_pkg::modem_lines_t lines_in,
    output rx_status_pkg::modem_lines_t lines_q,
    output logic change_q
);
    rx_status_pkg::modem_lines_t prev_q;
    logic change_d;

    // Both edges of the three levels count; ring only when it comes on
    assign change_d = (lines_q.carrier ^ prev_q.carrier)
                    | (lines_q.cts ^ prev_q.cts)
                    | (lines_q.sec_rx ^ prev_q.sec_rx)
                    | (lines_q.ring & ~prev_q.ring);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lines_q <= '0;
            prev_q <= '0;
            change_q <= 1'b0;
        end else begin
            lines_q <= lines_in;
            prev_q <= lines_q;
            change_q <= change_d;
        end
    end

endmodule : modem_watch

// [hw/rx_status_ctl.sv]
// Receiver status and modem control register with AXI4-Lite access
// Function
// - clear-to-send status bit follows modem input
// - carrier bit reads one while carrier present
// - busy sets at start centre, clears later
// - reverse receive reads one at space
// - receive complete sets when character assembled
// - receive interrupt when complete and enabled
// - complete cleared by buffer access, advance, clear
// - modem interrupt when change flag and enabled
// - reverse transmit bit drives space level
// - request bit drives strap-selected modem lead
// - terminal ready survives bus clear pulse
// - tape advance write pulses reader, clears complete
// - tape advance clears at start bit middle
// - modem line changes set change flag; ring sets it only when it comes on
// - status read or bus clear drops flag
// - unused and write-only bits read zero
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "rx_status_defs.svh"

module rx_status_ctl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic bus_clear_pulse,
    input wire logic rx_start_mid,
    input wire logic rx_char_done,
    input wire logic [7:0] rx_char,
    input wire rx_status_pkg::modem_lines_t modem_in,
    input wire logic force_busy_strap,
    output logic request_send_out,
    output logic force_busy_out,
    output logic terminal_ready_out,
    output logic reverse_tx_space,
    output logic reader_advance,
    output logic rx_irq_req,
    output logic modem_irq_req,
    output logic irq
);
    function automatic rx_status_pkg::reg_sel_t decode(input logic [3:0] a);
        case (a)
            `OFF_RSC: decode = rx_status_pkg::SEL_RSC;
            `OFF_RECEIVE_BUFFER: decode = rx_status_pkg::SEL_RECEIVE_BUFFER;
            `OFF_IRQ_STS: decode = rx_status_pkg::SEL_IRQ_STS;
            `OFF_IRQ_MASK: decode = rx_status_pkg::SEL_IRQ_MASK;
            default: decode = rx_status_pkg::SEL_NONE;
        endcase
    endfunction : decode

    rx_status_pkg::modem_lines_t lines_q;
    logic change_q;

    modem_watch u_watch (
        .aclk(aclk),
        .aresetn(aresetn),
        .lines_in(modem_in),
        .lines_q(lines_q),
        .change_q(change_q)
    );

    logic aw_held_q, w_held_q;
    logic [3:0] awaddr_q;
    logic [7:0] wbyte_q;
    logic wlane_q;
    logic busy_q, sec_rx_q, done_q, done_prev_q, mchg_q;
    logic rx_ie_q, modem_ie_q, sec_tx_q, rts_q, dtr_q, tape_q;
    logic [7:0] receive_buffer_q;
    logic [1:0] irq_sts_q, irq_mask_q;
    logic strap_q, strap_taken_q;

    // Write path: address and data may come in either order
    logic aw_take, w_take, wr_go, rd_go;
    logic aw_held_d, w_held_d, bvalid_d, rvalid_d;
    assign aw_take = awvalid & awready;
    assign w_take = wvalid & wready;
    assign wr_go = aw_held_q & w_held_q & ~bvalid;
    assign aw_held_d = (aw_held_q & ~wr_go) | aw_take;
    assign w_held_d = (w_held_q & ~wr_go) | w_take;
    assign bvalid_d = wr_go | (bvalid & ~bready);
    assign rd_go = arvalid & arready;
    assign rvalid_d = rd_go | (rvalid & ~rready);

    rx_status_pkg::reg_sel_t wsel, rsel;
    assign wsel = decode(awaddr_q);
    assign rsel = decode(araddr);

    logic wr_en, wr_rsc, wr_sts, wr_mask;
    assign wr_en = wr_go & wlane_q;
    assign wr_rsc = wr_en & (wsel == rx_status_pkg::SEL_RSC);
    assign wr_sts = wr_en & (wsel == rx_status_pkg::SEL_IRQ_STS);
    assign wr_mask = wr_en & (wsel == rx_status_pkg::SEL_IRQ_MASK);

    logic rd_rsc, buf_touch, tape_set;
    assign rd_rsc = rd_go & (rsel == rx_status_pkg::SEL_RSC);
    // A write to the buffer is refused but still counts as addressing it
    assign buf_touch = (rd_go & (rsel == rx_status_pkg::SEL_RECEIVE_BUFFER))
                     | (wr_go & (wsel == rx_status_pkg::SEL_RECEIVE_BUFFER));
    assign tape_set = wr_rsc & wbyte_q[`B_TAPE];

    // Flag next values; a hardware set always beats a clear
    logic done_d, busy_d, mchg_d, tape_d, done_rise;
    logic [1:0] sts_set, sts_d;
    assign done_d = rx_char_done
                  | (done_q & ~(buf_touch | tape_set | bus_clear_pulse));
    assign done_rise = done_q & ~done_prev_q;
    assign busy_d = rx_start_mid
                  | (busy_q & ~(done_rise | bus_clear_pulse));
    assign mchg_d = change_q | (mchg_q & ~(rd_rsc | bus_clear_pulse));
    // Software raising the advance beats the start-bit clear
    assign tape_d = tape_set
                  | (tape_q & ~(rx_start_mid | bus_clear_pulse));
    assign sts_set = {change_q, rx_char_done};
    assign sts_d = sts_set | (irq_sts_q & ~(wr_sts ? wbyte_q[1:0] : 2'h0));

    logic [15:0] rsc_view;
    assign rsc_view = {mchg_q, lines_q.ring, lines_q.cts, lines_q.carrier,
                       busy_q, sec_rx_q, 2'h0, done_q, rx_ie_q, modem_ie_q,
                       1'b0, sec_tx_q, rts_q, dtr_q, 1'b0};

    logic [31:0] rd_word;
    always_comb begin
        case (rsel)
            rx_status_pkg::SEL_RSC: rd_word = {16'h0000, rsc_view};
            rx_status_pkg::SEL_RECEIVE_BUFFER: rd_word = {24'h000000, receive_buffer_q};
            rx_status_pkg::SEL_IRQ_STS: rd_word = {30'h0, irq_sts_q};
            rx_status_pkg::SEL_IRQ_MASK: rd_word = {30'h0, irq_mask_q};
            default: rd_word = 32'h00000000;
        endcase
    end

    logic wr_bad;
    assign wr_bad = (wsel == rx_status_pkg::SEL_NONE) | (wsel == rx_status_pkg::SEL_RECEIVE_BUFFER);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 4'h0;
            wbyte_q <= `RST_BYTE;
            wlane_q <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= rx_status_pkg::RESP_OKAY;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            awready <= ~aw_held_d & ~bvalid_d;
            wready <= ~w_held_d & ~bvalid_d;
            bvalid <= bvalid_d;
            if (aw_take) begin
                awaddr_q <= awaddr;
            end
            if (w_take) begin
                wbyte_q <= wdata[7:0];
                wlane_q <= wstrb[0];
            end
            if (wr_go) begin
                bresp <= wr_bad ? rx_status_pkg::RESP_SLVERR : rx_status_pkg::RESP_OKAY;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= rx_status_pkg::RESP_OKAY;
        end else begin
            arready <= ~rvalid_d;
            rvalid <= rvalid_d;
            if (rd_go) begin
                rdata <= rd_word;
                rresp <= (rsel == rx_status_pkg::SEL_NONE) ?
                         rx_status_pkg::RESP_SLVERR : rx_status_pkg::RESP_OKAY;
            end
        end
    end

    // Status flags and the receive buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_q <= 1'b0;
            done_prev_q <= 1'b0;
            busy_q <= 1'b0;
            mchg_q <= 1'b0;
            tape_q <= 1'b0;
            sec_rx_q <= 1'b0;
            receive_buffer_q <= `RST_BYTE;
            irq_sts_q <= `RST_IRQ2;
        end else begin
            done_q <= done_d;
            done_prev_q <= done_q;
            busy_q <= busy_d;
            mchg_q <= mchg_d;
            tape_q <= tape_d;
            sec_rx_q <= lines_q.sec_rx & ~bus_clear_pulse;
            irq_sts_q <= sts_d;
            if (rx_char_done) begin
                receive_buffer_q <= rx_char;
            end
        end
    end

    // Control bits; terminal ready ignores the bus clear pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_ie_q <= 1'b0;
            modem_ie_q <= 1'b0;
            sec_tx_q <= 1'b0;
            rts_q <= 1'b0;
            dtr_q <= 1'b0;
            irq_mask_q <= `RST_IRQ2;
        end else begin
            if (wr_rsc) begin
                rx_ie_q <= wbyte_q[`B_RX_IE];
                modem_ie_q <= wbyte_q[`B_MODEM_IE];
                sec_tx_q <= wbyte_q[`B_SEC_TX];
                rts_q <= wbyte_q[`B_RTS];
                dtr_q <= wbyte_q[`B_DTR];
            end else if (bus_clear_pulse) begin
                rx_ie_q <= 1'b0;
                modem_ie_q <= 1'b0;
                sec_tx_q <= 1'b0;
                rts_q <= 1'b0;
            end
            if (wr_mask) begin
                irq_mask_q <= wbyte_q[1:0];
            end
        end
    end

    // Strap is caught once, on the first edge after reset release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_q <= 1'b0;
            strap_taken_q <= 1'b0;
        end else if (!strap_taken_q) begin
            strap_q <= force_busy_strap;
            strap_taken_q <= 1'b1;
        end
    end

    // Pin and request outputs, one cycle behind the flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            request_send_out <= 1'b0;
            force_busy_out <= 1'b0;
            terminal_ready_out <= 1'b0;
            reverse_tx_space <= 1'b0;
            reader_advance <= 1'b0;
            rx_irq_req <= 1'b0;
            modem_irq_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            request_send_out <= rts_q & ~strap_q;
            force_busy_out <= rts_q & strap_q;
            terminal_ready_out <= dtr_q;
            reverse_tx_space <= sec_tx_q;
            reader_advance <= tape_q;
            rx_irq_req <= done_q & rx_ie_q;
            modem_irq_req <= mchg_q & modem_ie_q;
            irq <= |(irq_sts_q & irq_mask_q);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence carrier_flip;
        $changed(modem_in.carrier) && $stable(aresetn);
    endsequence

    sequence flag_seen;
        ##3 mchg_q;
    endsequence

    // The status bit is one register behind the pin
    cts_track_a: assert property (
        $past(aresetn) |-> rsc_view[`B_CTS] == $past(modem_in.cts))
        else $error("cts status does not follow input");

    carrier_change_a: assert property (
        carrier_flip |-> flag_seen)
        else $error("carrier change did not set change flag");

    busy_set_a: assert property (
        rx_start_mid |=> busy_q)
        else $error("busy not set at start bit");

    // Busy drops only on a rising edge of complete or a bus clear pulse, so an overrun is excluded
    done_set_a: assert property (
        rx_char_done && !done_q |=> done_q ##1 busy_q == 1'b0 || $past(rx_start_mid))
        else $error("complete or busy wrong after character");

    done_clear_a: assert property (
        buf_touch && !rx_char_done |=> !done_q)
        else $error("buffer access did not clear complete");

    rx_irq_level_a: assert property (
        done_q && rx_ie_q |=> rx_irq_req)
        else $error("receive request missing");

    req_drop_a: assert property (
        !mchg_q |=> !modem_irq_req)
        else $error("modem request held without flag");

    read_clear_a: assert property (
        rd_rsc && !change_q |=> !mchg_q)
        else $error("status read did not clear change flag");

    tape_clear_a: assert property (
        rx_start_mid && !tape_set |=> !tape_q ##1 !reader_advance)
        else $error("advance not cleared at start bit");

    dtr_keep_a: assert property (
        bus_clear_pulse && !wr_rsc |=> $stable(dtr_q))
        else $error("bus clear changed terminal ready");

endmodule : rx_status_ctl

// [verification/modem_dataset_model.sv]
// Behavioural modem dataset that feeds line status to the receiver block
`timescale 1ns/1ps

module modem_dataset_model (
    input wire logic aclk,
    input wire rx_status_pkg::modem_lines_t want,
    input wire logic terminal_ready,
    input wire logic request_send,
    output rx_status_pkg::modem_lines_t lines
);
    rx_status_pkg::modem_lines_t q = '0;

    // Lines move only just after an edge, as a synchronised dataset would
    always @(posedge aclk) begin
        q <= want;
    end

    // Off the channel there is no carrier, and no clear-to-send without a request
    assign lines = {q.carrier & terminal_ready, q.cts & request_send, q.ring, q.sec_rx};
endmodule : modem_dataset_model

// [verification/serial_rx_status_modem_ctl_tb_top.sv]
// Self-checking bench for the receiver status and modem control block
`timescale 1ns/1ps

module serial_rx_status_modem_ctl_tb_top;
    typedef struct {
        logic [31:0] wv;
        logic [31:0] rv;
        logic [3:0] outs;
    } row_t;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    // Response channels stay ready, so back-to-back calls never toggle them in one step
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h1, arvalid = 1'h0, rready = 1'h1;
    logic [31:0] wdata = 32'h0;
    logic bus_clear_pulse = 1'h0, rx_start_mid = 1'h0, rx_char_done = 1'h0, strap = 1'h0;
    logic [7:0] rx_char = 8'h00;
    logic awready, wready, bvalid, arready, rvalid, rts, fbusy, dtr, stx, adv;
    logic rx_irq, m_irq, irq;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, seen;
    rx_status_pkg::modem_lines_t want = '0, lines;
    int n_fail = 0;
    int num_checks = 0;
    row_t rows [4];
    logic [3:0] steps [6];
    logic flags [6];

    always #12.5 aclk = ~aclk;

    rx_status_ctl DUT (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .bus_clear_pulse(bus_clear_pulse), .rx_start_mid(rx_start_mid),
        .rx_char_done(rx_char_done), .rx_char(rx_char), .modem_in(lines),
        .force_busy_strap(strap), .request_send_out(rts), .force_busy_out(fbusy),
        .terminal_ready_out(dtr), .reverse_tx_space(stx), .reader_advance(adv),
        .rx_irq_req(rx_irq), .modem_irq_req(m_irq), .irq(irq)
    );

    modem_dataset_model modem (
        .aclk(aclk), .want(want), .terminal_ready(dtr), .request_send(rts), .lines(lines)
    );

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        // The slave may take address and data on different edges
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_ok = 1'h1;
                awvalid <= 1'h0;
            end
            if (wvalid && wready) begin
                w_ok = 1'h1;
                wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        resp = bresp;
    endtask : wr

    task automatic rc(input logic [3:0] a, input logic [31:0] exp, input string name);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
        seen = rdata;
        resp = rresp;
        chk(name, exp, seen);
    endtask : rc

    task automatic char_in(input logic [7:0] c);
        rx_char <= c;
        rx_char_done <= 1'h1;
        cyc(1);
        rx_char_done <= 1'h0;
    endtask : char_in

    function automatic logic [31:0] mexp(input logic [3:0] m, input logic f);
        return {16'h0, f, m[1], m[2], m[3], 1'h0, m[0], 10'h026};
    endfunction : mexp

    task automatic stop_test;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        rows = '{'{32'h6e, 32'h6e, 4'he}, '{32'hffff, 32'h6e, 4'hf},
            '{32'h0, 32'h0, 4'h1}, '{32'h8, 32'h8, 4'h9}};
        steps = '{4'h8, 4'hc, 4'he, 4'hf, 4'hd, 4'h9};
        flags = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1};
        cyc(4);
        aresetn <= 1'h1;
        cyc(1);
        rc(4'h0, 32'h0, "reset value");
        chk("read resp", {30'h0, rx_status_pkg::RESP_OKAY}, {30'h0, resp});
        foreach (rows[i]) begin
            wr(4'h0, rows[i].wv);
            rc(4'h0, rows[i].rv, "control readback");
            chk("control outputs", {28'h0, rows[i].outs}, {28'h0, stx, rts, dtr, adv});
        end
        $display("test register rows done");
        wr(4'h0, 32'h26);
        chk("write resp", {30'h0, rx_status_pkg::RESP_OKAY}, {30'h0, resp});
        foreach (steps[i]) begin
            want <= steps[i];
            cyc(6);
            chk("modem request", {31'h0, flags[i]}, {31'h0, m_irq});
            rc(4'h0, mexp(steps[i], flags[i]), "modem status");
            cyc(3);
            chk("modem request drop", 32'h0, {31'h0, m_irq});
        end
        want <= 4'h0;
        cyc(6);
        rc(4'h0, mexp(4'h0, 1'h1), "lines all off");
        $display("test modem lines done");
        wr(4'h8, 32'h3);
        wr(4'hc, 32'h1);
        wr(4'h0, 32'h40);
        rx_start_mid <= 1'h1;
        cyc(1);
        rx_start_mid <= 1'h0;
        cyc(2);
        chk("advance after start", 32'h0, {31'h0, adv});
        rc(4'h0, 32'h840, "busy set");
        char_in(8'ha5);
        cyc(4);
        chk("rx request", 32'h1, {31'h0, rx_irq});
        chk("irq line", 32'h1, {31'h0, irq});
        rc(4'h0, 32'hc0, "complete set");
        rc(4'h4, 32'ha5, "buffer data");
        cyc(2);
        chk("rx request drop", 32'h0, {31'h0, rx_irq});
        rc(4'h0, 32'h40, "complete cleared");
        wr(4'h8, 32'h1);
        cyc(2);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(4'hc, 32'h0);
        char_in(8'h3c);
        cyc(4);
        chk("irq masked", 32'h0, {31'h0, irq});
        rc(4'h8, 32'h1, "irq status");
        wr(4'h0, 32'h41);
        rc(4'h0, 32'h40, "advance clears complete");
        chk("advance out", 32'h1, {31'h0, adv});
        wr(4'h4, 32'h0);
        chk("buffer write resp", {30'h0, rx_status_pkg::RESP_SLVERR}, {30'h0, resp});
        rc(4'h2, 32'h0, "unmapped read");
        chk("unmapped read resp", {30'h0, rx_status_pkg::RESP_SLVERR}, {30'h0, resp});
        $display("test receive path done");
        wr(4'h0, 32'h6e);
        bus_clear_pulse <= 1'h1;
        cyc(1);
        bus_clear_pulse <= 1'h0;
        cyc(2);
        rc(4'h0, 32'h2, "after bus clear");
        chk("outputs after clear", 32'h2, {28'h0, stx, rts, dtr, adv});
        // The strap is only caught after a reset, so a second reset is needed
        strap <= 1'h1;
        aresetn <= 1'h0;
        cyc(4);
        aresetn <= 1'h1;
        cyc(1);
        wr(4'h0, 32'h4);
        cyc(2);
        chk("strap lead", 32'h2, {30'h0, fbusy, rts});
        $display("test clear and strap done");
        stop_test;
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        n_fail++;
        stop_test;
    end
endmodule : serial_rx_status_modem_ctl_tb_top
